// file: design/inm_pkg.sv
// shared constants and types of the two-wire memory host controller
package inm_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int QTR_CYC       = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam int QTR_W         = 7;
  localparam logic [QTR_W-1:0] QTR_LAST = QTR_W'(QTR_CYC - 1);

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_LEN  = 8'h08;
  localparam logic [7:0] OFS_TXD  = 8'h0c;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_RXD  = 8'h14;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL_GO      = 0;
  localparam int CTRL_CMD_LO  = 1;
  localparam int CTRL_WP      = 3;
  localparam int CTRL_SEL_LO  = 4;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_DONE    = 1;
  localparam int STAT_NACK    = 2;
  localparam int STAT_TXEMPTY = 3;
  localparam int STAT_RXVALID = 4;
  localparam int ADDR_W       = 13;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [1:0]        RST_CMD  = 2'h0;
  localparam logic [2:0]        RST_SEL  = 3'h0;
  localparam logic [ADDR_W-1:0] RST_ADDR = 13'h0000;
  localparam logic [7:0]        RST_LEN  = 8'h00;

  // ----------------------------------------
  // commands, states, byte kinds
  // ----------------------------------------
  typedef enum logic [1:0] {
    CMD_WRITE = 2'h0,
    CMD_CUR   = 2'h1,
    CMD_RND   = 2'h2
  } inm_cmd_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_START   = 3'h1,
    ST_BIT     = 3'h2,
    ST_ACK     = 3'h3,
    ST_STOP    = 3'h4,
    ST_WAIT_TX = 3'h5,
    ST_WAIT_RX = 3'h6
  } inm_state_t;

  typedef enum logic [2:0] {
    K_DEV_W = 3'h0,
    K_AHI   = 3'h1,
    K_ALO   = 3'h2,
    K_WDATA = 3'h3,
    K_DEV_R = 3'h4,
    K_RDATA = 3'h5
  } inm_kind_t;

endpackage : inm_pkg

// file: design/inm_sync.sv
// two flip-flop synchroniser for a pin input
`timescale 1ns/1ps
module inm_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic din,
  output logic      dout
);

  logic meta_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b1;
      dout   <= 1'b1;
    end else begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end

endmodule : inm_sync

// file: design/inm_tick.sv
// quarter-period tick for the serial clock
`timescale 1ns/1ps
module inm_tick (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick
);

  logic [inm_pkg::QTR_W-1:0] cnt_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      tick <= (cnt_r == inm_pkg::QTR_LAST);
      if (cnt_r == inm_pkg::QTR_LAST) begin
        cnt_r <= '0;
      end else begin
        cnt_r <= cnt_r + inm_pkg::QTR_W'(1);
      end
    end
  end

endmodule : inm_tick

// file: design/inm_host.sv
// two-wire memory host: apb registers, byte sequencer and pin driver
//
// Local design decisions: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
// Notes on behaviour
// R1 - receiver pulls data low on the ninth clock after each byte
// R2 - transmitter releases data on the ninth clock so the acknowledge is seen
// R3 - device abandons operation on stop before any low acknowledge
// R4 - after not-acknowledge the bus is released, then stop or start follows
// R5 - first byte: 4-bit type code, 3-bit select code, direction bit
// R6 - device answers only when type and select code match its straps
// R7 - direction bit 0 means write, 1 means read
// R8 - two memory address bytes follow, high byte first, each acknowledged
// R9 - host always drives clock; data direction follows direction bit
// R10 - during writes the next byte goes only after the acknowledge
// R11 - during reads device sends eight bits then waits for acknowledge
// R12 - device needs no busy time; no acknowledge polling after writes
// R13 - write protect pin high blocks all writes; reads always work
// R14 - byte write: start, address word, two address bytes, data, stop
// R15 - top three bits of the high address byte are zero
// R16 - further write bytes go to successive addresses, wrapping to zero
// R17 - each byte is committed when its acknowledge completes
// R18 - current read returns last accessed address plus one, wrapping
// R19 - address counter undefined after power-up until set
// R20 - current read: start, read word, one byte, not-acknowledge, stop
// R21 - random read: address write, repeated start, read word, byte, not-acknowledge
// R22 - sequential read continues from rising addresses while acknowledged
// R23 - device samples data on clock rise, changes it after clock fall
// R24 - data changes only while clock low, except start and stop
// R25 - every byte is sent most significant bit first
// R26 - device address counter advances after every data byte
module inm_host #(
  parameter logic [3:0] DEV_TYPE = 4'h6  // arbitrary value; set to the target's type code
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             scl_o,
  output logic             scl_oe,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        sda_i,
  output logic             wp_o
);

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  inm_pkg::inm_state_t               st_r;
  inm_pkg::inm_kind_t                kind_r;
  logic [1:0]                        q_r;
  logic [2:0]                        bit_r;
  logic [7:0]                        shift_r;
  logic [7:0]                        left_r;
  logic                              ack_bad_r;
  logic                              tick;
  logic                              sda_s;
  logic [1:0]                        cmd_r;
  logic [2:0]                        sel_r;
  logic                              wp_r;
  logic [inm_pkg::ADDR_W-1:0]        addr_r;
  logic [7:0]                        len_r;
  logic [7:0]                        txd_r;
  logic                              tx_full_r;
  logic [7:0]                        rxd_r;
  logic                              rx_valid_r;
  logic                              done_r;
  logic                              nack_r;
  logic                              scl_hi_r;
  logic                              sda_oe_r;
  logic [31:0]                       prdata_r;
  logic                              go;
  logic                              wr_acc;
  logic                              rd_acc;
  logic                              mapped;
  logic                              tx_take;
  logic                              rx_set;
  logic                              done_set;
  logic                              nack_set;
  logic                              rx_kind;
  logic                              last_byte;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  inm_tick u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  inm_sync u_sda_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (sda_i),
    .dout    (sda_s)
  );

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  assign mapped  = (paddr == inm_pkg::OFS_CTRL) || (paddr == inm_pkg::OFS_ADDR) ||
                   (paddr == inm_pkg::OFS_LEN)  || (paddr == inm_pkg::OFS_TXD)  ||
                   (paddr == inm_pkg::OFS_STAT) || (paddr == inm_pkg::OFS_RXD);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_r;
  assign wr_acc  = psel && penable && pwrite && mapped;
  assign rd_acc  = psel && penable && !pwrite && mapped;
  assign go      = wr_acc && (paddr == inm_pkg::OFS_CTRL) && pwdata[inm_pkg::CTRL_GO] &&
                   (st_r == inm_pkg::ST_IDLE) && (pwdata[2:1] != 2'h3);

  // read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      case (paddr)
        inm_pkg::OFS_CTRL: prdata_r <= {25'h0, sel_r, wp_r, cmd_r, 1'b0};
        inm_pkg::OFS_ADDR: prdata_r <= {19'h0, addr_r};
        inm_pkg::OFS_LEN:  prdata_r <= {24'h0, len_r};
        inm_pkg::OFS_TXD:  prdata_r <= {24'h0, txd_r};
        inm_pkg::OFS_STAT: prdata_r <= {27'h0, rx_valid_r, !tx_full_r, nack_r, done_r,
                                        st_r != inm_pkg::ST_IDLE};
        inm_pkg::OFS_RXD:  prdata_r <= {24'h0, rxd_r};
        default:           prdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_r  <= inm_pkg::RST_CMD;
      sel_r  <= inm_pkg::RST_SEL;
      wp_r   <= 1'b0;
      addr_r <= inm_pkg::RST_ADDR;
      len_r  <= inm_pkg::RST_LEN;
    end else if (wr_acc) begin
      case (paddr)
        inm_pkg::OFS_CTRL: begin
          cmd_r <= pwdata[inm_pkg::CTRL_CMD_LO +: 2];
          sel_r <= pwdata[inm_pkg::CTRL_SEL_LO +: 3];
          wp_r  <= pwdata[inm_pkg::CTRL_WP];
        end
        inm_pkg::OFS_ADDR: addr_r <= pwdata[inm_pkg::ADDR_W-1:0];
        inm_pkg::OFS_LEN:  len_r  <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  assign wp_o = wp_r;

  // transmit holding byte; software write wins over the engine taking it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txd_r     <= 8'h00;
      tx_full_r <= 1'b0;
    end else if (wr_acc && (paddr == inm_pkg::OFS_TXD)) begin
      txd_r     <= pwdata[7:0];
      tx_full_r <= 1'b1;
    end else if (tx_take) begin
      tx_full_r <= 1'b0;
    end
  end

  // receive byte; a new byte wins over the read that clears the flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxd_r      <= 8'h00;
      rx_valid_r <= 1'b0;
    end else if (rx_set) begin
      rxd_r      <= shift_r;
      rx_valid_r <= 1'b1;
    end else if (rd_acc && (paddr == inm_pkg::OFS_RXD)) begin
      rx_valid_r <= 1'b0;
    end
  end

  // sticky status, write one to clear, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_r <= 1'b0;
      nack_r <= 1'b0;
    end else begin
      if (done_set) begin
        done_r <= 1'b1;
      end else if (wr_acc && (paddr == inm_pkg::OFS_STAT) && pwdata[inm_pkg::STAT_DONE]) begin
        done_r <= 1'b0;
      end
      if (nack_set) begin
        nack_r <= 1'b1;
      end else if (wr_acc && (paddr == inm_pkg::OFS_STAT) && pwdata[inm_pkg::STAT_NACK]) begin
        nack_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // byte sequencer
  // ----------------------------------------
  assign rx_kind   = (kind_r == inm_pkg::K_RDATA);
  assign last_byte = (left_r == 8'h00);
  assign tx_take   = (st_r == inm_pkg::ST_WAIT_TX) && tx_full_r;
  assign rx_set    = tick && (st_r == inm_pkg::ST_BIT) && (q_r == 2'd3) && (bit_r == 3'd7) && rx_kind;
  assign done_set  = tick && (st_r == inm_pkg::ST_STOP) && (q_r == 2'd3);
  assign nack_set  = tick && (st_r == inm_pkg::ST_ACK) && (q_r == 2'd3) && !rx_kind && ack_bad_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r      <= inm_pkg::ST_IDLE;
      kind_r    <= inm_pkg::K_DEV_W;
      q_r       <= 2'd0;
      bit_r     <= 3'd0;
      shift_r   <= 8'h00;
      left_r    <= 8'h00;
      ack_bad_r <= 1'b0;
    end else begin
      case (st_r)
        inm_pkg::ST_IDLE: begin
          if (go) begin
            st_r   <= inm_pkg::ST_START;
            left_r <= len_r;
            kind_r <= (pwdata[2:1] == inm_pkg::CMD_CUR) ? inm_pkg::K_DEV_R : inm_pkg::K_DEV_W;  // R20
          end
        end
        inm_pkg::ST_START: begin
          if (tick) begin
            q_r <= q_r + 2'd1;
            if (q_r == 2'd3) begin
              shift_r <= {DEV_TYPE, sel_r, kind_r == inm_pkg::K_DEV_R};  // R5
              st_r    <= inm_pkg::ST_BIT;
            end
          end
        end
        inm_pkg::ST_BIT: begin
          if (tick) begin
            q_r <= q_r + 2'd1;
            if (q_r == 2'd2) begin
              shift_r <= {shift_r[6:0], sda_s};  // R25
            end
            if (q_r == 2'd3) begin
              bit_r <= bit_r + 3'd1;
              if (bit_r == 3'd7) begin
                st_r <= inm_pkg::ST_ACK;  // R1
              end
            end
          end
        end
        inm_pkg::ST_ACK: begin
          if (tick) begin
            q_r <= q_r + 2'd1;
            if (q_r == 2'd2) begin
              ack_bad_r <= sda_s;
            end
            if (q_r == 2'd3) begin
              if (!rx_kind && ack_bad_r) begin
                st_r <= inm_pkg::ST_STOP;  // R4
              end else begin
                case (kind_r)
                  inm_pkg::K_DEV_W: begin
                    kind_r  <= inm_pkg::K_AHI;
                    shift_r <= {3'b000, addr_r[12:8]};  // R8 R15
                    st_r    <= inm_pkg::ST_BIT;
                  end
                  inm_pkg::K_AHI: begin
                    kind_r  <= inm_pkg::K_ALO;
                    shift_r <= addr_r[7:0];  // R8
                    st_r    <= inm_pkg::ST_BIT;
                  end
                  inm_pkg::K_ALO: begin
                    if (cmd_r == inm_pkg::CMD_RND) begin
                      kind_r <= inm_pkg::K_DEV_R;  // R21
                      st_r   <= inm_pkg::ST_START;
                    end else begin
                      kind_r <= inm_pkg::K_WDATA;  // R14
                      st_r   <= inm_pkg::ST_WAIT_TX;
                    end
                  end
                  inm_pkg::K_WDATA: begin
                    if (last_byte) begin
                      st_r <= inm_pkg::ST_STOP;  // R14
                    end else begin
                      left_r <= left_r - 8'd1;
                      st_r   <= inm_pkg::ST_WAIT_TX;  // R10
                    end
                  end
                  inm_pkg::K_DEV_R: begin
                    kind_r <= inm_pkg::K_RDATA;
                    st_r   <= inm_pkg::ST_BIT;
                  end
                  default: begin
                    if (last_byte) begin
                      st_r <= inm_pkg::ST_STOP;  // R20
                    end else begin
                      left_r <= left_r - 8'd1;
                      st_r   <= inm_pkg::ST_WAIT_RX;
                    end
                  end
                endcase
              end
            end
          end
        end
        inm_pkg::ST_WAIT_TX: begin
          if (tx_full_r) begin
            shift_r <= txd_r;
            st_r    <= inm_pkg::ST_BIT;
          end
        end
        inm_pkg::ST_WAIT_RX: begin
          if (!rx_valid_r) begin
            st_r <= inm_pkg::ST_BIT;
          end
        end
        inm_pkg::ST_STOP: begin
          if (tick) begin
            q_r <= q_r + 2'd1;
            if (q_r == 2'd3) begin
              st_r <= inm_pkg::ST_IDLE;
            end
          end
        end
        default: st_r <= inm_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // pin driver
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_hi_r <= 1'b1;
      sda_oe_r <= 1'b0;
    end else if (tick) begin
      case (st_r)
        inm_pkg::ST_START: begin
          case (q_r)
            2'd0:    sda_oe_r <= 1'b0;
            2'd1:    scl_hi_r <= 1'b1;
            2'd2:    sda_oe_r <= 1'b1;  // R24
            default: scl_hi_r <= 1'b0;
          endcase
        end
        inm_pkg::ST_BIT: begin
          case (q_r)
            2'd0:    sda_oe_r <= !rx_kind && !shift_r[7];  // R9 R24 R25
            2'd1:    scl_hi_r <= 1'b1;
            2'd3:    scl_hi_r <= 1'b0;
            default: ;
          endcase
        end
        inm_pkg::ST_ACK: begin
          case (q_r)
            2'd0:    sda_oe_r <= rx_kind && !last_byte;  // R1 R2 R20
            2'd1:    scl_hi_r <= 1'b1;
            2'd3:    scl_hi_r <= 1'b0;
            default: ;
          endcase
        end
        inm_pkg::ST_STOP: begin
          case (q_r)
            2'd0:    sda_oe_r <= 1'b1;
            2'd1:    scl_hi_r <= 1'b1;
            2'd2:    sda_oe_r <= 1'b0;  // R24
            default: ;
          endcase
        end
        default: ;
      endcase
    end
  end

  assign scl_o  = 1'b0;
  assign scl_oe = !scl_hi_r;
  assign sda_o  = 1'b0;
  assign sda_oe = sda_oe_r;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_byte_end;
    (st_r == inm_pkg::ST_BIT) && tick && (q_r == 2'd3) && (bit_r == 3'd7);
  endsequence

  sequence s_start_end;
    (st_r == inm_pkg::ST_START) && tick && (q_r == 2'd3);
  endsequence

  a_ninth_clock: assert property (s_byte_end |=> st_r == inm_pkg::ST_ACK)  // R1 R2
    else $error("ack slot did not follow eighth bit");

  a_ack_release: assert property ((st_r == inm_pkg::ST_ACK) && !rx_kind && (q_r != 2'd0) |-> !sda_oe_r)  // R2
    else $error("data driven during device acknowledge");

  a_ack_drive: assert property ((st_r == inm_pkg::ST_ACK) && rx_kind && !last_byte && (q_r != 2'd0)
                                |-> sda_oe_r)  // R1
    else $error("read byte not acknowledged low");

  a_nack_last: assert property ((st_r == inm_pkg::ST_ACK) && rx_kind && last_byte && (q_r != 2'd0)
                                |-> !sda_oe_r)  // R20
    else $error("last read byte not answered with not-acknowledge");

  a_nack_stop: assert property (nack_set |=> (st_r == inm_pkg::ST_STOP) ##1 nack_r)  // R4
    else $error("not-acknowledge not followed by stop");

  a_devword_fmt: assert property (s_start_end |=> (shift_r[7:4] == DEV_TYPE) && (shift_r[3:1] == sel_r)
                                  && (shift_r[0] == (kind_r == inm_pkg::K_DEV_R)))  // R5
    else $error("address word malformed");

  a_addr_hi_zero: assert property ((st_r == inm_pkg::ST_BIT) && (kind_r == inm_pkg::K_AHI) && (bit_r < 3'd3)
                                   && (q_r != 2'd0) |-> sda_oe_r)  // R15
    else $error("high address byte top bits not zero");

  a_sda_scl_low: assert property ($changed(sda_oe_r) && (st_r != inm_pkg::ST_START) && (st_r != inm_pkg::ST_STOP)
                                  |-> !scl_hi_r && !$past(scl_hi_r))  // R24
    else $error("data changed while clock high");

  a_msb_first: assert property ((st_r == inm_pkg::ST_BIT) && !rx_kind && tick && (q_r == 2'd0)
                                |=> sda_oe_r == !$past(shift_r[7]))  // R25
    else $error("bit order wrong");

endmodule : inm_host

// file: testbench/inm_mem_model.sv
// behavioural model of the two-wire byte memory
`timescale 1ns/1ps
module inm_mem_model #(
  parameter logic [3:0] TYPE = 4'h9,  // arbitrary type code
  parameter logic [2:0] SEL  = 3'h5
) (
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic wp,
  output logic      pull
);
  localparam int DW = 0, AH = 1, AL = 2, WD = 3, RD = 4, IDLE = 5;
  logic [7:0]  mem [8192];
  logic [7:0]  sh;
  logic [12:0] addr;
  int          ph = IDLE;
  int          bitc = 0;
  initial begin
    pull = 1'b0;
    addr = 13'h0abc;
    foreach (mem[i]) mem[i] = 8'(i) ^ 8'h5a;
  end
  // ----------------------------------------
  // start, stop, bit engine
  // ----------------------------------------
  always @(negedge sda) if (scl) begin
    ph = DW;
    bitc = 0;
    pull = 1'b0;
  end
  always @(posedge sda) if (scl) begin
    ph = IDLE;
    pull = 1'b0;
  end
  always @(posedge scl) if (ph != IDLE) begin
    if (bitc < 8) sh = {sh[6:0], sda};
    else if (ph == RD && sda) ph = IDLE;
    bitc++;
  end
  always @(negedge scl) if (ph != IDLE) begin
    if (bitc == 8) begin
      pull = 1'b1;
      case (ph)
        DW: if (sh[7:1] != {TYPE, SEL}) begin
          ph = IDLE;
          pull = 1'b0;
        end
        AH: addr[12:8] = sh[4:0];
        AL: addr[7:0] = sh;
        RD: begin
          pull = 1'b0;
          addr++;
        end
        default: ;
      endcase
    end else if (bitc == 9) begin
      pull = 1'b0;
      bitc = 0;
      if (ph == WD) begin
        if (!wp) mem[addr] = sh;
        addr++;
      end
      ph = (ph == DW) ? (sh[0] ? RD : AH) : (ph >= WD) ? ph : ph + 1;
    end
    if (ph == RD && bitc < 8) pull = !mem[addr][7-bitc];
  end
endmodule : inm_mem_model

// file: testbench/inm_host_tb.sv
// self-checking bench of the two-wire memory host
`timescale 1ns/1ps
module inm_host_tb;
  logic        pclk, presetn, psel, penable, pwrite, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  logic        pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, wp_o, pull;
  wire logic   scl = scl_oe ? scl_o : 1'b1;
  wire logic   sda = (sda_oe ? sda_o : 1'b1) & !pull;
  int          miscompares = 0;
  int          cmp_count = 0;

  inm_host #(.DEV_TYPE(4'h9)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .sda_i(sda), .wp_o(wp_o));
  inm_mem_model #(.TYPE(4'h9), .SEL(3'h5)) u_mem (.scl(scl), .sda(sda), .wp(wp_o), .pull(pull));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic poll(input int b);
    int n;
    n = 0;
    q = '0;
    while (q[b] !== 1'b1 && n < 20000) begin
      apb(1'b0, inm_pkg::OFS_STAT, 32'h0);
      n++;
    end
    chk(32'(q[b]), 32'h1);
  endtask : poll
  task automatic xfer(input logic [1:0] cmd, input logic [2:0] sel, input logic wp,
                      input logic [12:0] a, input logic [7:0] v[$], input logic nack);
    apb(1'b1, inm_pkg::OFS_ADDR, 32'(a));
    apb(1'b1, inm_pkg::OFS_LEN, 32'(v.size() - 1));
    if (cmd == inm_pkg::CMD_WRITE) apb(1'b1, inm_pkg::OFS_TXD, 32'(v[0]));
    apb(1'b1, inm_pkg::OFS_CTRL, 32'({sel, wp, cmd, 1'b1}));
    for (int i = 1; i < v.size() && cmd == inm_pkg::CMD_WRITE; i++) begin
      poll(inm_pkg::STAT_TXEMPTY);
      apb(1'b1, inm_pkg::OFS_TXD, 32'(v[i]));
    end
    for (int i = 0; i < v.size() && cmd != inm_pkg::CMD_WRITE; i++) begin
      poll(inm_pkg::STAT_RXVALID);
      apb(1'b0, inm_pkg::OFS_RXD, 32'h0);
      chk(q, 32'(v[i]));
    end
    poll(inm_pkg::STAT_DONE);
    chk(32'(q[inm_pkg::STAT_NACK]), 32'(nack));
    apb(1'b1, inm_pkg::OFS_STAT, 32'h6);
  endtask : xfer
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, 8'h1c, 32'h0);
    chk(32'(err), 32'h1);
    chk(q, 32'h0);
    apb(1'b1, inm_pkg::OFS_CTRL, 32'h7);
    apb(1'b0, inm_pkg::OFS_STAT, 32'h0);
    chk(q, 32'h8);
    $display("test registers done");
    xfer(inm_pkg::CMD_WRITE, 3'h5, 1'b0, 13'h1ffe, {8'h11, 8'h22, 8'h33}, 1'b0);
    chk(32'(u_mem.mem[13'h1ffe]), 32'h11);
    chk(32'(u_mem.mem[13'h1fff]), 32'h22);
    chk(32'(u_mem.mem[13'h0000]), 32'h33);
    $display("test page write done");
    xfer(inm_pkg::CMD_CUR, 3'h5, 1'b0, 13'h0, {8'h5b}, 1'b0);
    $display("test current read done");
    xfer(inm_pkg::CMD_RND, 3'h5, 1'b0, 13'h1fff, {8'h22, 8'h33, 8'h5b}, 1'b0);
    $display("test sequential read done");
    xfer(inm_pkg::CMD_WRITE, 3'h5, 1'b1, 13'h0010, {8'ha5}, 1'b0);
    chk(32'(wp_o), 32'h1);
    chk(32'(u_mem.mem[13'h0010]), 32'h4a);
    $display("test write protect done");
    xfer(inm_pkg::CMD_WRITE, 3'h2, 1'b0, 13'h0020, {8'hee}, 1'b1);
    chk(32'(u_mem.mem[13'h0020]), 32'h7a);
    $display("test wrong select done");
    stop_test();
  end
  initial begin
    repeat (99000) @(posedge pclk);
    miscompares++;
    stop_test();
  end
endmodule : inm_host_tb
